// file: src/fec_pkg.sv
// Notes on behaviour
// - small wipes ignored in uniform layout
// - finished small wipe leaves sector all ones
// - wipes need write latch set first
// - 20h address length per config; 21h four bytes
// - D8h address length per config; DCh four bytes
// - erase starts only on exact-length chip-select rise
// - busy flag high during erase, low after
// - protected target sets wipe error, no erase
// - small wipe outside parameter sectors skipped silently
// - config bit selects 64 or 256 KB block
// - block wipe spares overlaid parameter sectors
// - uniform layout: block wipe clears whole blocks
// - persistent and volatile lock per physical sector
// - 256 KB range with locked sector errors
// - full wipe needs rise after eighth bit
// - full wipe dropped silently if range locks set
// - full wipe skips locked sectors silently
// - verify sets status2 bit2 from erase state
// - verify busy during evaluation; host polls status
// - verify sets latch itself, clears at end
// - four-line mode moves instruction and address
// - erase cycle pre-programs then erases
package fec_pkg;
	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_SMALL = 8'h20;
	localparam logic [7:0] OP_SMALL4 = 8'h21;
	localparam logic [7:0] OP_BLK = 8'hD8;
	localparam logic [7:0] OP_BLK4 = 8'hDC;
	localparam logic [7:0] OP_FULL_A = 8'h60;
	localparam logic [7:0] OP_FULL_B = 8'hC7;
	localparam logic [7:0] OP_VERIFY = 8'hD0;
	localparam logic [7:0] OP_WLSET = 8'h06;
	localparam logic [7:0] OP_RDS1 = 8'h05;
	localparam logic [7:0] OP_RDS2 = 8'h07;
	// ----------------------------------------
	// frame lengths in bits
	// ----------------------------------------
	localparam logic [6:0] OPC_BITS = 7'h08;
	localparam logic [6:0] ADDR3_BITS = 7'h18;
	localparam logic [6:0] ADDR4_BITS = 7'h20;
	localparam logic [6:0] CNT_MAX = 7'h7F;
	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int ST1_BUSY = 0;
	localparam int ST1_WLATCH = 1;
	localparam int ST1_ERR = 5;
	localparam int ST2_EOK = 2;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int N_PARAM = 8;
	localparam int SEC_SHIFT = 16;
	localparam int PSEC_SHIFT = 12;
	localparam int PARAM_HALF_BIT = 15;
	// ----------------------------------------
	// reset values and default counts
	// ----------------------------------------
	localparam logic ERASED_RST = 1'b1;
	localparam int PREP_CYC_DEF = 64;
	localparam int ERASE_CYC_DEF = 256;
	localparam int EVAL_CYC_DEF = 16;
	localparam int HOST_HALF_DEF = 4;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PREP = 2'b01,
		ST_ERAS = 2'b10,
		ST_EVAL = 2'b11
	} fec_st_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_RUN = 2'b01,
		H_END = 2'b10
	} fec_hst_t;
endpackage

// file: src/fec_if.sv
// serial link between controller and flash end
interface fec_if;
	logic sck;
	logic cs_n;
	logic [3:0] h_io;
	logic [3:0] h_oe;
	logic [3:0] d_io;
	logic [3:0] d_oe;
	logic [3:0] io;
	// wire level: device, then host, else pulled high
	assign io = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe);
	modport dev (input sck, input cs_n, input io, output d_io, output d_oe);
	modport host (output sck, output cs_n, output h_io, output h_oe, input io);
endinterface

// file: src/fec_dev.sv
module fec_dev #(
	parameter int NSEC = 128,
	parameter int UW = $clog2(NSEC + 8),
	parameter int PREP_CYC = fec_pkg::PREP_CYC_DEF,
	parameter int ERASE_CYC = fec_pkg::ERASE_CYC_DEF,
	parameter int EVAL_CYC = fec_pkg::EVAL_CYC_DEF
) (
	fec_if.dev LNK,
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic ADDR4,
	input wire logic UNIFORM,
	input wire logic BIG_BLOCK,
	input wire logic PARAM_TOP,
	input wire logic FOUR_LINE,
	input wire logic [2:0] RANGE_LOCK,
	input wire logic LOCK_WR,
	input wire logic LOCK_PERSIST,
	input wire logic [UW-1:0] LOCK_IDX,
	input wire logic LOCK_VAL,
	input wire logic [UW-1:0] Q_IDX,
	output logic Q_ERASED,
	output logic BUSY,
	output logic WRITE_LATCH,
	output logic WIPE_ERR,
	output logic ERASE_OK,
	output logic [1:0] PHASE
);
	import fec_pkg::*;
	localparam int NU = NSEC + N_PARAM;
	localparam int SW = $clog2(NSEC);

	// protection by range bits: top 2^(bp-1) sectors
	function automatic logic bp_cover(input int idx, input logic [2:0] bp);
		bp_cover = (bp != 3'h0) && (idx >= NSEC - (1 << (int'(bp) - 1)));
	endfunction

	// ----------------------------------------
	// link clock domain
	// ----------------------------------------
	logic quad_m_r, quad_s_r;
	logic frm_r;
	logic [6:0] cnt_r, cnt_nxt, cnt_base, step;
	logic [39:0] sh_r, sh_nxt;
	logic [7:0] op_r;
	logic [3:0] fl_m_r, fl_s_r;
	logic [3:0] oe_r, do_r;
	logic [7:0] sbyte;
	logic rd_sel;
	wire clr_n = RST_N & ~LNK.cs_n;

	// mode sync into link domain
	always_ff @(posedge LNK.sck or negedge RST_N) begin
		if (!RST_N) begin
			quad_m_r <= 1'b0;
			quad_s_r <= 1'b0;
		end else begin
			quad_m_r <= FOUR_LINE;
			quad_s_r <= quad_m_r;
		end
	end

	// frame marker, cleared while deselected
	always_ff @(posedge LNK.sck or negedge clr_n) begin
		if (!clr_n) frm_r <= 1'b0;
		else frm_r <= 1'b1;
	end

	always_comb begin
		cnt_base = frm_r ? cnt_r : 7'h00;
		step = quad_s_r ? 7'h04 : 7'h01;
		cnt_nxt = (cnt_base > CNT_MAX - step) ? CNT_MAX : cnt_base + step;
		sh_nxt = quad_s_r ? {sh_r[35:0], LNK.io} : {sh_r[38:0], LNK.io[0]};
	end

	// shifter and bit counter, held after the frame
	always_ff @(posedge LNK.sck or negedge RST_N) begin
		if (!RST_N) begin
			cnt_r <= 7'h00;
			sh_r <= 40'h0;
			op_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			if (cnt_nxt == OPC_BITS) op_r <= sh_nxt[7:0];
		end
	end

	// status flags into link domain
	always_ff @(posedge LNK.sck or negedge RST_N) begin
		if (!RST_N) begin
			fl_m_r <= 4'h0;
			fl_s_r <= 4'h0;
		end else begin
			fl_m_r <= {ERASE_OK, WIPE_ERR, WRITE_LATCH, BUSY};
			fl_s_r <= fl_m_r;
		end
	end

	always_comb begin
		sbyte = 8'h00;
		if (op_r == OP_RDS2) begin
			sbyte[ST2_EOK] = fl_s_r[3];
		end else begin
			sbyte[ST1_BUSY] = fl_s_r[0];
			sbyte[ST1_WLATCH] = fl_s_r[1];
			sbyte[ST1_ERR] = fl_s_r[2];
		end
		rd_sel = (op_r == OP_RDS1) || (op_r == OP_RDS2);
	end

	// output on falling edge, msb first
	always_ff @(negedge LNK.sck or negedge clr_n) begin
		if (!clr_n) begin
			oe_r <= 4'h0;
			do_r <= 4'h0;
		end else begin
			oe_r <= 4'h0;
			if (rd_sel && cnt_r >= OPC_BITS) oe_r <= quad_s_r ? 4'hF : 4'h2;
			if (quad_s_r) do_r <= cnt_r[2] ? sbyte[3:0] : sbyte[7:4];
			else do_r <= {2'b00, sbyte[3'h7 - cnt_r[2:0]], 1'b0};
		end
	end
	assign LNK.d_io = do_r;
	assign LNK.d_oe = oe_r;

	// ----------------------------------------
	// core clock domain
	// ----------------------------------------
	fec_st_t st_r, st_nxt;
	logic cs_m_r, cs_s_r, cs_d_r;
	logic [31:0] tmr_r;
	logic [NU-1:0] lk_p_r, lk_v_r, ok_r, mask_r;
	logic [NU-1:0] prot, lkd, blk_mask, full_mask, small_mask, new_mask;
	logic [UW-1:0] vunit_r, vunit;
	logic [6:0] alen;
	logic [31:0] addr;
	logic [SW-1:0] sec, psec;
	logic in_param, len_a, len_8, rise, acc, tdone;
	logic is_small, is_blk, is_full;
	logic start, reject, skip, vstart, wlset, fin;

	// chip-select sync; shifter is quiet after the rise
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cs_m_r <= 1'b1;
			cs_s_r <= 1'b1;
			cs_d_r <= 1'b1;
		end else begin
			cs_m_r <= LNK.cs_n;
			cs_s_r <= cs_m_r;
			cs_d_r <= cs_s_r;
		end
	end

	// lock bit tables
	generate
		for (genvar g = 0; g < NU; g++) begin : g_prot
			localparam int PAR = (g < NSEC) ? g : 0;
			assign lkd[g] = lk_p_r[g] | lk_v_r[g];
			assign prot[g] = lkd[g] | bp_cover(g < NSEC ? PAR : (PARAM_TOP ? NSEC - 1 : 0), RANGE_LOCK);
			if (g < NSEC) begin : g_sec
				localparam logic [SW-1:0] GI = SW'(PAR);
				// 64 KB or 256 KB group
				assign blk_mask[g] = BIG_BLOCK ? (GI[SW-1:2] == sec[SW-1:2]) : (GI == sec);
				assign small_mask[g] = 1'b0;
				assign full_mask[g] = ~lkd[g];
			end else begin : g_par
				assign blk_mask[g] = 1'b0;
				assign small_mask[g] = (g - NSEC) == int'(addr[PSEC_SHIFT +: 3]);
				assign full_mask[g] = ~lkd[g] & ~UNIFORM;
			end
		end
	endgenerate

	// frame decode at the chip-select rise
	always_comb begin
		rise = cs_s_r & ~cs_d_r;
		acc = rise && (st_r == ST_IDLE) && (cnt_r >= OPC_BITS);
		is_small = (op_r == OP_SMALL) || (op_r == OP_SMALL4);
		is_blk = (op_r == OP_BLK) || (op_r == OP_BLK4);
		is_full = (op_r == OP_FULL_A) || (op_r == OP_FULL_B);
		alen = (op_r == OP_SMALL4 || op_r == OP_BLK4 || ADDR4) ? ADDR4_BITS : ADDR3_BITS;
		len_a = cnt_r == OPC_BITS + alen;
		len_8 = cnt_r == OPC_BITS;
		addr = (alen == ADDR4_BITS) ? sh_r[31:0] : {8'h00, sh_r[23:0]};
		sec = addr[SEC_SHIFT +: SW];
		psec = PARAM_TOP ? SW'(NSEC - 1) : '0;
		in_param = !UNIFORM && (sec == psec) && (addr[PARAM_HALF_BIT] == PARAM_TOP);
		vunit = in_param ? UW'(NSEC + int'(addr[PSEC_SHIFT +: 3])) : UW'(sec);
		start = 1'b0;
		reject = 1'b0;
		skip = 1'b0;
		new_mask = '0;
		wlset = acc && len_8 && (op_r == OP_WLSET);
		vstart = acc && len_a && (op_r == OP_VERIFY);
		if (acc && WRITE_LATCH && len_a && is_small && !UNIFORM) begin
			if (!in_param) skip = 1'b1;
			else if (|(small_mask & prot)) reject = 1'b1;
			else begin
				start = 1'b1;
				new_mask = small_mask;
			end
		end
		if (acc && WRITE_LATCH && len_a && is_blk) begin
			if (|(blk_mask & prot)) reject = 1'b1;
			else begin
				start = 1'b1;
				new_mask = blk_mask;
			end
		end
		if (acc && WRITE_LATCH && len_8 && is_full) begin
			if (RANGE_LOCK != 3'h0) skip = 1'b1;
			else begin
				start = 1'b1;
				new_mask = full_mask;
			end
		end
	end

	always_comb begin
		tdone = tmr_r == 32'h0;
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (start) st_nxt = ST_PREP;
				else if (vstart) st_nxt = ST_EVAL;
			end
			ST_PREP: if (tdone) st_nxt = ST_ERAS;
			ST_ERAS: if (tdone) st_nxt = ST_IDLE;
			ST_EVAL: if (tdone) st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
		fin = (st_r != ST_IDLE) && (st_nxt == ST_IDLE);
	end

	// sequencer, timer, busy
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= ST_IDLE;
			tmr_r <= 32'h0;
			BUSY <= 1'b0;
		end else begin
			st_r <= st_nxt;
			BUSY <= st_nxt != ST_IDLE;
			if (st_r == ST_IDLE && start) tmr_r <= 32'(PREP_CYC - 1);
			else if (st_r == ST_IDLE && vstart) tmr_r <= 32'(EVAL_CYC - 1);
			else if (st_r == ST_PREP && tdone) tmr_r <= 32'(ERASE_CYC - 1);
			else if (!tdone) tmr_r <= tmr_r - 32'h1;
		end
	end
	assign PHASE = st_r;

	// region and erased state per unit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_r <= '0;
			ok_r <= {NU{ERASED_RST}};
			vunit_r <= '0;
		end else begin
			if (start) begin
				mask_r <= new_mask;
				ok_r <= ok_r & ~new_mask;
			end else if (fin && st_r == ST_ERAS) begin
				ok_r <= ok_r | mask_r;
			end
			if (vstart) vunit_r <= vunit;
		end
	end

	// lock bit loading
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lk_p_r <= '0;
			lk_v_r <= '0;
		end else if (LOCK_WR && int'(LOCK_IDX) < NU) begin
			if (LOCK_PERSIST) lk_p_r[LOCK_IDX] <= LOCK_VAL;
			else lk_v_r[LOCK_IDX] <= LOCK_VAL;
		end
	end

	// write latch, set wins
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) WRITE_LATCH <= 1'b0;
		else if (wlset || vstart) WRITE_LATCH <= 1'b1;
		else if (fin || reject || skip) WRITE_LATCH <= 1'b0;
	end

	// error flag and verify result
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			WIPE_ERR <= 1'b0;
			ERASE_OK <= 1'b0;
			Q_ERASED <= ERASED_RST;
		end else begin
			if (reject) WIPE_ERR <= 1'b1;
			else if (start) WIPE_ERR <= 1'b0;
			if (fin && st_r == ST_EVAL) ERASE_OK <= ok_r[vunit_r];
			Q_ERASED <= (int'(Q_IDX) < NU) ? ok_r[Q_IDX] : 1'b0;
		end
	end
endmodule // fec_dev

// file: src/fec_host.sv
module fec_host #(
	parameter int HALF = fec_pkg::HOST_HALF_DEF
) (
	fec_if.host LNK,
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_OP,
	input wire logic [31:0] CMD_ADDR,
	input wire logic [2:0] CMD_ABYTES,
	input wire logic CMD_RD,
	input wire logic CMD_QUAD,
	output logic CMD_READY,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA
);
	import fec_pkg::*;
	fec_hst_t st_r;
	logic [15:0] div_r;
	logic tick;
	logic sck_r, cs_n_r, quad_r;
	logic [3:0] io_r, oe_r, in_m_r, in_s_r;
	logic [39:0] sh_r, sh_nxt;
	logic [6:0] n_r, n_nxt, tx_r, tot_r, step;
	logic [7:0] rx_r;

	// input pins sync
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			in_m_r <= 4'h0;
			in_s_r <= 4'h0;
		end else begin
			in_m_r <= LNK.io;
			in_s_r <= in_m_r;
		end
	end

	// half period divider
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) div_r <= 16'h0;
		else if (st_r == H_IDLE || tick) div_r <= 16'h0;
		else div_r <= div_r + 16'h1;
	end

	always_comb begin
		tick = div_r == 16'(HALF - 1);
		step = quad_r ? 7'h04 : 7'h01;
		n_nxt = n_r + step;
		sh_nxt = quad_r ? {sh_r[35:0], 4'h0} : {sh_r[38:0], 1'b0};
	end

	// frame sequencer
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= H_IDLE;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			quad_r <= 1'b0;
			io_r <= 4'h0;
			oe_r <= 4'h0;
			sh_r <= 40'h0;
			n_r <= 7'h00;
			tx_r <= 7'h00;
			tot_r <= 7'h00;
			rx_r <= 8'h00;
			CMD_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA <= 8'h00;
		end else begin
			RSP_VALID <= 1'b0;
			case (st_r)
				H_IDLE: begin
					CMD_READY <= 1'b1;
					if (CMD_VALID && CMD_READY) begin
						CMD_READY <= 1'b0;
						st_r <= H_RUN;
						cs_n_r <= 1'b0;
						quad_r <= CMD_QUAD;
						n_r <= 7'h00;
						if (CMD_ABYTES == 3'h4) sh_r <= {CMD_OP, CMD_ADDR};
						else if (CMD_ABYTES == 3'h3) sh_r <= {CMD_OP, CMD_ADDR[23:0], 8'h00};
						else sh_r <= {CMD_OP, 32'h0};
						tx_r <= OPC_BITS + (CMD_ABYTES == 3'h4 ? ADDR4_BITS : (CMD_ABYTES == 3'h3 ? ADDR3_BITS : 7'h00));
						tot_r <= OPC_BITS + (CMD_ABYTES == 3'h4 ? ADDR4_BITS : (CMD_ABYTES == 3'h3 ? ADDR3_BITS : 7'h00))
							+ (CMD_RD ? OPC_BITS : 7'h00);
						io_r <= CMD_QUAD ? CMD_OP[7:4] : {3'b000, CMD_OP[7]};
						oe_r <= CMD_QUAD ? 4'hF : 4'h1;
					end
				end
				H_RUN: begin
					if (tick && !sck_r) begin
						sck_r <= 1'b1;
						n_r <= n_nxt;
						if (n_r >= tx_r) rx_r <= quad_r ? {rx_r[3:0], in_s_r} : {rx_r[6:0], in_s_r[1]};
					end else if (tick) begin
						sck_r <= 1'b0;
						if (n_r == tot_r) begin
							cs_n_r <= 1'b1;
							oe_r <= 4'h0;
							st_r <= H_END;
						end else begin
							sh_r <= sh_nxt;
							io_r <= quad_r ? sh_nxt[39:36] : {3'b000, sh_nxt[39]};
							if (n_r >= tx_r) oe_r <= 4'h0;
						end
					end
				end
				H_END: begin
					if (tick) begin
						st_r <= H_IDLE;
						RSP_VALID <= 1'b1;
						RSP_DATA <= rx_r;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	assign LNK.sck = sck_r;
	assign LNK.cs_n = cs_n_r;
	assign LNK.h_io = io_r;
	assign LNK.h_oe = oe_r;
endmodule // fec_host

// file: tb/fec_chk_sva.sv
module fec_chk #(
	parameter int EVAL_CYC = 16
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] d_oe,
	input wire logic BUSY,
	input wire logic WRITE_LATCH,
	input wire logic WIPE_ERR,
	input wire logic [1:0] PHASE
);
	localparam int EV_LO = EVAL_CYC - 10;
	localparam int EV_HI = EVAL_CYC - 2;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// link and erase sequencing
	// ----------------------------------------
	erase_busy_a: assert property ($rose(PHASE == 2'b10) |-> BUSY)
		else $error("erase phase without busy");
	prep_first_a: assert property ($rose(PHASE == 2'b10) |-> $past(PHASE) == 2'b01)
		else $error("erase not preceded by preprogram");
	start_on_rise_a: assert property ($rose(BUSY) |-> cs_n && $past(cs_n, 3))
		else $error("busy rose without frame end");
	dev_quiet_a: assert property (cs_n && $past(cs_n) |-> d_oe == 4'h0)
		else $error("device drives while deselected");
	sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("link clock runs outside frame");
	latch_drop_a: assert property ($fell(BUSY) |-> ##[0:2] !WRITE_LATCH)
		else $error("latch kept after operation");
	verify_latch_a: assert property ($rose(PHASE == 2'b11) |-> ##[0:2] WRITE_LATCH)
		else $error("verify did not set latch");
	verify_len_a: assert property ($rose(PHASE == 2'b11) |-> BUSY [*8] ##[EV_LO:EV_HI] !BUSY)
		else $error("verify busy length wrong");
	err_no_run_a: assert property ($rose(WIPE_ERR) |-> !BUSY)
		else $error("error flagged while erasing");
	wipe_run_c: cover property ($rose(PHASE == 2'b01));
	verify_run_c: cover property ($rose(PHASE == 2'b11));
	err_seen_c: cover property ($rose(WIPE_ERR));
endmodule // fec_chk

// file: tb/fec_tb_top.sv
module fec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fec_pkg::*;
	typedef struct packed {logic [7:0] val; logic [7:0] mask;} fec_note_t;
	fec_note_t notes[$];
	int errors = 0;
	int total_checks = 0;
	logic clk, rst_n, addr4, uniform, big_block, four_line, lock_wr, lock_persist, lock_val;
	logic [2:0] range_lock;
	logic [7:0] lock_idx, q_idx;
	logic q_erased, busy, write_latch, wipe_err, erase_ok;
	logic [1:0] phase;
	logic cmd_valid, cmd_rd, cmd_quad, cmd_ready, rsp_valid;
	logic [7:0] cmd_op, rsp_data;
	logic [31:0] cmd_addr;
	logic [2:0] cmd_abytes;
	logic [7:0] t_op[6] = '{8'h20, 8'h21, 8'hD8, 8'hDC, 8'h20, 8'hD8};
	logic [2:0] t_ab[6] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h4, 3'h4};
	logic t_a4[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic t_big[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic [31:0] adr;
	fec_if i_fec_if();
	fec_dev i_fec_dev (.LNK(i_fec_if), .CLK(clk), .RST_N(rst_n), .ADDR4(addr4), .UNIFORM(uniform),
		.BIG_BLOCK(big_block), .PARAM_TOP(1'b0), .FOUR_LINE(four_line), .RANGE_LOCK(range_lock),
		.LOCK_WR(lock_wr), .LOCK_PERSIST(lock_persist), .LOCK_IDX(lock_idx), .LOCK_VAL(lock_val),
		.Q_IDX(q_idx), .Q_ERASED(q_erased), .BUSY(busy), .WRITE_LATCH(write_latch), .WIPE_ERR(wipe_err),
		.ERASE_OK(erase_ok), .PHASE(phase));
	fec_host i_fec_host (.LNK(i_fec_if), .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_ADDR(cmd_addr), .CMD_ABYTES(cmd_abytes), .CMD_RD(cmd_rd), .CMD_QUAD(cmd_quad),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
	fec_chk #(.EVAL_CYC(EVAL_CYC_DEF)) i_fec_chk (.CLK(clk), .RST_N(rst_n), .sck(i_fec_if.sck),
		.cs_n(i_fec_if.cs_n), .d_oe(i_fec_if.d_oe), .BUSY(busy), .WRITE_LATCH(write_latch),
		.WIPE_ERR(wipe_err), .PHASE(phase));
	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// response monitor pops the oldest note
	always @(posedge clk) begin
		if (rsp_valid === 1'b1) begin
			if (notes.size() == 0) begin
				check("unexpected response", 8'h01, 8'h00);
			end else begin
				check("response", rsp_data & notes[0].mask, notes[0].val);
				void'(notes.pop_front());
			end
		end
	end
	// ----------------------------------------
	// command driver
	// ----------------------------------------
	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [2:0] ab, input logic rd,
		input logic [7:0] exp, input logic [7:0] msk);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("ready", {7'h0, cmd_ready}, 8'h01);
		notes.push_back('{exp, msk});
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_abytes <= ab;
		cmd_rd <= rd;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("response seen", {7'h0, rsp_valid}, 8'h01);
		repeat (8) @(posedge clk);
	endtask
	task automatic st1(input logic [7:0] exp);
		cmd(OP_RDS1, 32'h0, 3'h0, 1'b1, exp, 8'h23);
	endtask
	task automatic wipe(input logic [7:0] op, input logic [31:0] a, input logic [2:0] ab);
		cmd(OP_WLSET, 32'h0, 3'h0, 1'b0, 8'h00, 8'h00);
		cmd(op, a, ab, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 1000) begin
			@(posedge clk);
			n++;
		end
		check("busy", {7'h0, busy}, {7'h0, lvl});
	endtask
	// ----------------------------------------
	// clock, watchdog and scenarios
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		print_verdict();
	end
	initial begin
		{addr4, uniform, big_block, four_line, lock_wr, lock_persist, lock_val, cmd_valid} <= 8'h00;
		{cmd_rd, cmd_quad, range_lock, lock_idx, q_idx, cmd_op, cmd_addr, cmd_abytes} <= '0;
		rst_n <= 1'b0;
		void'($urandom(16));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		st1(8'h00);
		cmd(OP_BLK, 32'h0003_0000, 3'h3, 1'b0, 8'h00, 8'h00);
		st1(8'h00);
		for (int i = 0; i < 6; i++) begin
			addr4 <= t_a4[i];
			big_block <= t_big[i];
			adr = (t_op[i][3]) ? {8'h00, 1'b0, 7'($urandom_range(120, 1)), 16'h0000} : 32'h0000_1000;
			wipe(t_op[i], adr, t_ab[i]);
			wait_busy(1'b1);
			st1(8'h03);
			wait_busy(1'b0);
			st1(8'h00);
			q_idx <= (t_op[i][3]) ? adr[23:16] : 8'h81;
			repeat (2) @(posedge clk);
			check("erased", {7'h0, q_erased}, 8'h01);
		end
		{addr4, big_block} <= 2'b00;
		wipe(OP_BLK, 32'h0004_0000, 3'h4);
		st1(8'h02);
		cmd(OP_BLK, 32'h0004_0000, 3'h3, 1'b0, 8'h00, 8'h00);
		wait_busy(1'b1);
		wait_busy(1'b0);
		uniform <= 1'b1;
		wipe(OP_SMALL, 32'h0000_1000, 3'h3);
		st1(8'h02);
		uniform <= 1'b0;
		cmd(OP_SMALL, 32'h0003_0000, 3'h3, 1'b0, 8'h00, 8'h00);
		st1(8'h00);
		range_lock <= 3'h1;
		wipe(OP_FULL_A, 32'h0, 3'h0);
		st1(8'h00);
		wipe(OP_BLK, 32'h007F_0000, 3'h3);
		st1(8'h20);
		big_block <= 1'b1;
		wipe(OP_BLK, 32'h007C_0000, 3'h3);
		st1(8'h20);
		big_block <= 1'b0;
		range_lock <= 3'h0;
		lock_idx <= 8'($urandom_range(127, 0));
		lock_persist <= 1'($urandom_range(1, 0));
		lock_val <= 1'b1;
		lock_wr <= 1'b1;
		@(posedge clk);
		lock_wr <= 1'b0;
		wipe(OP_FULL_A, 32'h0, 3'h0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		st1(8'h00);
		four_line <= 1'b1;
		cmd_quad <= 1'b1;
		// link side takes a new mode on link clock edges only: dummy frame first
		cmd(OP_RDS1, 32'h0, 3'h0, 1'b0, 8'h00, 8'h00);
		wipe(OP_FULL_B, 32'h0, 3'h0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		st1(8'h00);
		four_line <= 1'b0;
		cmd_quad <= 1'b0;
		// dummy frame carries single-line mode into the link side
		cmd(OP_RDS1, 32'h0, 3'h0, 1'b0, 8'h00, 8'h00);
		cmd(OP_VERIFY, 32'h0005_0000, 3'h3, 1'b0, 8'h00, 8'h00);
		wait_busy(1'b1);
		check("latch", {7'h0, write_latch}, 8'h01);
		wait_busy(1'b0);
		cmd(OP_RDS2, 32'h0, 3'h0, 1'b1, 8'h04, 8'h04);
		st1(8'h00);
		check("notes left", 8'(notes.size()), 8'h00);
		print_verdict();
	end
endmodule // fec_tb_top
